// *** design/rx_pcs_lane_align_status.sv ***
// receive lane alignment status outputs for a twenty lane pcs
// assumes lane detectors deliver per-lane events and levels on I_CLK_SYS
`timescale 1ns/1ns
module rx_pcs_lane_align_status
  import lane_status_pkg::*;
#(
  parameter int METAFRAME_WORDS = 16384
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  // per-lane detector inputs
  input wire logic i_word_valid,
  input wire logic [NUM_LANES-1:0] i_block_lock,
  input wire logic [NUM_LANES-1:0] i_wordsync_achieved,
  input wire logic [NUM_LANES-1:0] i_sync_header_lost,
  input wire logic [NUM_LANES-1:0] i_marker_seen,
  input wire logic [NUM_LANES-1:0] i_marker_bad,
  input wire logic [NUM_LANES*LANE_IDX_W-1:0] i_lane_physical_index,
  // aligner and fault inputs
  input wire logic i_deskew_done,
  input wire logic i_align_error,
  input wire logic i_high_error_rate_state,
  input wire logic i_remote_fault,
  input wire logic i_received_local_fault,
  // configuration
  input wire logic [INTERVAL_W-1:0] i_marker_interval_setting,
  // per-lane status
  output logic [NUM_LANES-1:0] o_lane_wordsync_achieved,
  output logic [NUM_LANES-1:0] o_lane_wordsync_done,
  output logic [NUM_LANES-1:0] o_lane_wordsync_error,
  output logic [NUM_LANES-1:0] o_lane_marker_spacing_error,
  output logic [NUM_LANES-1:0] o_lane_marker_repeat_error,
  output logic [NUM_LANES-1:0] o_lane_marker_malformed,
  output logic [NUM_LANES-1:0] o_block_lock,
  output logic [NUM_LANES*LANE_IDX_W-1:0] o_pcs_lane_physical_index,
  // overall status
  output logic o_aligned,
  output logic o_align_loss,
  output logic o_misalignment_pulse,
  output logic o_pcs_status,
  output logic o_remote_fault,
  output logic o_local_fault
);
  localparam int MF_W = $clog2(METAFRAME_WORDS + 1);

  typedef struct packed {
    logic [NUM_LANES-1:0] marker_got;
    logic [NUM_LANES-1:0] wsync;
    logic [NUM_LANES-1:0] wsync_done;
    logic [NUM_LANES-1:0] wsync_err;
    logic [NUM_LANES-1:0] malformed;
    logic [NUM_LANES-1:0] lock;
    logic [NUM_LANES*LANE_IDX_W-1:0] phys;
    align_state_type align_st;
    logic mis_pending;
    logic [MF_W-1:0] mf_cnt;
    logic aligned;
    logic align_loss;
    logic mis_pulse;
    logic status;
    logic remote;
    logic local_f;
  } state_type;

  state_type q, d;
  logic [NUM_LANES-1:0] spacing_err;
  logic [NUM_LANES-1:0] repeat_err;

  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++) begin : lane_chk
      lane_marker_check u_chk (
        .i_clk(I_CLK_SYS),
        .i_reset_n(I_RESET_N),
        .i_enable(q.wsync[g]),
        .i_word_valid(i_word_valid),
        .i_marker_seen(i_marker_seen[g]),
        .i_marker_bad(i_marker_bad[g]),
        .i_interval(i_marker_interval_setting),
        .o_spacing_error(spacing_err[g]),
        .o_repeat_error(repeat_err[g])
      );
    end
  endgenerate

  always_comb begin
    logic all_ok;
    logic bad_any;
    all_ok = 1'b0;
    bad_any = 1'b0;
    d = q;
    d.wsync = i_wordsync_achieved;
    d.lock = i_block_lock;
    // a marker must be seen after each sync acquisition
    d.marker_got = q.marker_got & i_wordsync_achieved;
    if (i_word_valid) begin
      d.marker_got = d.marker_got | (i_marker_seen & i_wordsync_achieved);
    end
    d.wsync_done = d.marker_got;
    d.wsync_err = i_sync_header_lost | ~d.marker_got;
    d.malformed = i_word_valid ? (i_marker_seen & i_marker_bad) : '0;
    for (int i = 0; i < NUM_LANES; i++) begin
      if (d.marker_got[i]) begin
        d.phys[i*LANE_IDX_W +: LANE_IDX_W] =
          i_lane_physical_index[i*LANE_IDX_W +: LANE_IDX_W];
      end
    end
    all_ok = i_deskew_done && (&d.marker_got);
    bad_any = |d.malformed;
    d.aligned = all_ok;
    d.status = all_ok && !i_high_error_rate_state;
    d.remote = i_remote_fault;
    d.local_f = !all_ok || i_received_local_fault;
    d.mis_pulse = 1'b0;
    unique case (q.align_st)
      ALIGN_NEVER: begin
        if (all_ok) begin
          d.align_st = ALIGN_SEEN;
        end
      end
      ALIGN_SEEN: begin
        if (!all_ok) begin
          d.align_st = ALIGN_LOST;
        end
      end
      ALIGN_LOST: begin
        if (all_ok) begin
          d.align_st = ALIGN_SEEN;
        end
      end
      // unused code; fall back as if never aligned
      default: begin
        d.align_st = ALIGN_NEVER;
      end
    endcase
    d.align_loss = i_align_error || (q.align_st == ALIGN_LOST);
    // report one metaframe after the bad marker; a new error restarts it
    if (q.mis_pending) begin
      if (q.mf_cnt == MF_W'(1)) begin
        d.mis_pulse = 1'b1;
        d.mis_pending = 1'b0;
      end else if (i_word_valid) begin
        d.mf_cnt = q.mf_cnt - MF_W'(1);
      end
    end
    if (bad_any && q.align_st != ALIGN_NEVER) begin
      d.mis_pending = 1'b1;
      d.mf_cnt = MF_W'(METAFRAME_WORDS);
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    o_lane_wordsync_achieved = q.wsync;
    o_lane_wordsync_done = q.wsync_done;
    o_lane_wordsync_error = q.wsync_err;
    o_lane_marker_spacing_error = spacing_err;
    o_lane_marker_repeat_error = repeat_err;
    o_lane_marker_malformed = q.malformed;
    o_block_lock = q.lock;
    o_pcs_lane_physical_index = q.phys;
    o_aligned = q.aligned;
    o_align_loss = q.align_loss;
    o_misalignment_pulse = q.mis_pulse;
    o_pcs_status = q.status;
    o_remote_fault = q.remote;
    o_local_fault = q.local_f;
  end
endmodule

// *** design/lane_status_pkg.sv ***
// constants shared by the receive lane status block
// assumes one core clock; lane detector events arrive already on it
package lane_status_pkg;
  localparam int NUM_LANES = 20;
  localparam int LANE_IDX_W = 5;
  localparam int INTERVAL_W = 16;
  localparam int REPEAT_LIMIT = 4;
  localparam int REPEAT_CNT_W = 3;
  localparam logic [REPEAT_CNT_W-1:0] REPEAT_CNT_ZERO = 3'h0;
  localparam logic [REPEAT_CNT_W-1:0] REPEAT_CNT_ONE = 3'h1;
  localparam logic [INTERVAL_W-1:0] INTERVAL_ZERO = 16'h0000;
  localparam logic [INTERVAL_W-1:0] INTERVAL_ONE = 16'h0001;
  localparam logic [LANE_IDX_W-1:0] LANE_IDX_RESET = 5'h00;

  typedef enum logic [1:0] {
    ALIGN_NEVER = 2'b00,
    ALIGN_SEEN = 2'b01,
    ALIGN_LOST = 2'b11
  } align_state_type;
endpackage

// *** design/lane_marker_check.sv ***
// per-lane marker spacing and repeated error checker
// assumes marker and word strobes are synchronous to the core clock
`timescale 1ns/1ns
module lane_marker_check
  import lane_status_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_enable,
  input wire logic i_word_valid,
  input wire logic i_marker_seen,
  input wire logic i_marker_bad,
  input wire logic [INTERVAL_W-1:0] i_interval,
  output logic o_spacing_error,
  output logic o_repeat_error
);
  typedef struct packed {
    logic [INTERVAL_W-1:0] word_cnt;
    logic [REPEAT_CNT_W-1:0] bad_cnt;
    logic spacing_err;
    logic repeat_err;
  } chk_type;

  chk_type q, d;

  always_comb begin
    logic on_time;
    on_time = 1'b0;
    d = q;
    if (!i_enable) begin
      d = '0;
    end else if (i_word_valid) begin
      on_time = (q.word_cnt == i_interval);
      if (i_marker_seen) begin
        d.word_cnt = INTERVAL_ZERO;
        d.spacing_err = !on_time;
      end else begin
        d.word_cnt = q.word_cnt + INTERVAL_ONE;
        // marker overdue also counts as wrong spacing
        if (on_time) begin
          d.spacing_err = 1'b1;
          d.word_cnt = INTERVAL_ZERO;
        end
      end
      if (i_marker_seen) begin
        if (i_marker_bad || !on_time) begin
          if (q.bad_cnt != REPEAT_CNT_W'(REPEAT_LIMIT)) begin
            d.bad_cnt = q.bad_cnt + REPEAT_CNT_ONE;
          end
        end else begin
          d.bad_cnt = REPEAT_CNT_ZERO;
        end
      end
      d.repeat_err = (d.bad_cnt == REPEAT_CNT_W'(REPEAT_LIMIT));
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_spacing_error = q.spacing_err;
  assign o_repeat_error = q.repeat_err;
endmodule

// *** tb/lane_src.sv ***
// far-side lane source: markers on all lanes every GAP+1 words
// assumes the bench picks which lanes send a malformed marker
`timescale 1ns/1ns
module lane_src #(
  parameter int GAP = 3
) (
  // clock
  input wire logic i_clk,
  // lanes to corrupt
  input wire logic [19:0] i_bad,
  // lane detector strobes
  output logic o_valid,
  output logic [19:0] o_marker,
  output logic [19:0] o_bad
);
  int cnt = 0;
  initial {o_marker, o_bad} = '0;
  // words on every cycle, so the marker stream never idles
  assign o_valid = 1'b1;
  always @(posedge i_clk) begin
    cnt <= (cnt == GAP) ? 0 : cnt + 1;
    o_marker <= {20{cnt == GAP}};
    o_bad <= (cnt == GAP) ? i_bad : '0;
  end
endmodule

// *** tb/rx_status_chk.sv ***
// port assertions for the lane status block
// assumes one core clock and an async active-low reset
`timescale 1ns/1ns
module rx_status_chk (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  // watched inputs
  input wire logic i_word_valid,
  input wire logic [19:0] i_marker_seen,
  input wire logic [19:0] i_marker_bad,
  input wire logic [19:0] i_block_lock,
  input wire logic [19:0] i_sync_header_lost,
  input wire logic i_deskew_done,
  input wire logic i_high_error_rate_state,
  input wire logic i_remote_fault,
  input wire logic i_received_local_fault,
  // watched outputs
  input wire logic [19:0] o_lane_wordsync_error,
  input wire logic [19:0] o_lane_marker_malformed,
  input wire logic [19:0] o_block_lock,
  input wire logic o_aligned,
  input wire logic o_misalignment_pulse,
  input wire logic o_pcs_status,
  input wire logic o_remote_fault,
  input wire logic o_local_fault
);
  logic seen_q;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
    if (!I_RESET_N) seen_q <= 1'b0;
    else if (o_aligned) seen_q <= 1'b1;
  a_malformed_pulse: assert property (1'b1 |=> o_lane_marker_malformed ==
    $past(i_marker_seen & i_marker_bad & {20{i_word_valid}})) else $error("bad pulse");
  a_aligned_gate: assert property (o_aligned |-> $past(i_deskew_done))
    else $error("aligned early");
  a_status_gate: assert property (o_pcs_status |-> !$past(i_high_error_rate_state))
    else $error("status in high ber");
  a_local_fault: assert property (i_received_local_fault |=> o_local_fault)
    else $error("local fault missed");
  a_remote_level: assert property (1'b1 |=> o_remote_fault == $past(i_remote_fault))
    else $error("remote fault wrong");
  a_lock_level: assert property (1'b1 |=> o_block_lock == $past(i_block_lock))
    else $error("block lock wrong");
  a_misalign_gate: assert property (o_misalignment_pulse |-> seen_q)
    else $error("misaligned before aligned");
  a_sync_error: assert property (|i_sync_header_lost |=>
    (o_lane_wordsync_error & $past(i_sync_header_lost)) == $past(i_sync_header_lost))
    else $error("sync error missed");
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the lane status block
// assumes a short metaframe and the marker source model
`timescale 1ns/1ns
module testbench;
  logic clk, rst_n, dk, ae, hb, rf, rlf, wv, o_al, o_ps, o_rf, o_lf, o_mp, o_los;
  logic e_rf, e_rlf, e_ae;
  logic [19:0] bl, sy, hl, bad, mk, mb, e_bl, e_mal, o_bl, o_mal, o_sp, o_rep, o_we;
  logic [19:0] o_ws, o_wd;
  logic [99:0] idx, o_idx;
  logic [15:0] ivl;
  int errors = 0, n_checks = 0, k;
  lane_src #(.GAP(3)) i_src (.i_clk(clk), .i_bad(bad), .o_valid(wv), .o_marker(mk),
    .o_bad(mb));
  rx_pcs_lane_align_status #(.METAFRAME_WORDS(8)) i_dut (.I_CLK_SYS(clk),
    .I_RESET_N(rst_n), .i_word_valid(wv), .i_block_lock(bl), .i_wordsync_achieved(sy),
    .i_sync_header_lost(hl), .i_marker_seen(mk), .i_marker_bad(mb),
    .i_lane_physical_index(idx), .i_deskew_done(dk), .i_align_error(ae),
    .i_high_error_rate_state(hb), .i_remote_fault(rf), .i_received_local_fault(rlf),
    .i_marker_interval_setting(ivl), .o_lane_wordsync_achieved(o_ws),
    .o_lane_wordsync_done(o_wd),
    .o_lane_wordsync_error(o_we), .o_lane_marker_spacing_error(o_sp),
    .o_lane_marker_repeat_error(o_rep), .o_lane_marker_malformed(o_mal),
    .o_block_lock(o_bl), .o_pcs_lane_physical_index(o_idx), .o_aligned(o_al),
    .o_align_loss(o_los), .o_misalignment_pulse(o_mp), .o_pcs_status(o_ps),
    .o_remote_fault(o_rf), .o_local_fault(o_lf));
  task automatic err(input string m);
    errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input bit ok, input string m);
    n_checks++;
    if (!ok) err(m);
  endtask
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // reference model, one cycle behind its inputs
  always @(posedge clk) begin
    {e_bl, e_rf, e_rlf, e_ae} <= rst_n ? {bl, rf, rlf, ae} : '0;
    e_mal <= rst_n ? (mk & mb & {20{wv}}) : '0;
  end
  always @(negedge clk) if (rst_n) begin
    check(o_bl === e_bl, "block lock");
    check(o_rf === e_rf, "remote fault");
    check(o_mal === e_mal, "malformed pulse");
    check(!(e_rlf && o_lf !== 1'b1), "local fault");
    check(!(e_ae && o_los !== 1'b1), "align loss");
  end
  initial begin
    rst_n = 0;
    {bl, sy, hl, bad, dk, ae, hb, rf, rlf} = '0;
    ivl = 16'h0003;
    k = $urandom(14455);
    for (int i = 0; i < 20; i++) idx[i*5 +: 5] = 5'($urandom_range(19));
    repeat (3) @(posedge clk);
    check({o_bl, o_mal, o_we, o_al, o_ps, o_rf, o_lf, o_mp} === '0, "reset");
    rst_n <= 1'b1;
    repeat (30) @(posedge clk) {bl, rf, rlf, hb, ae} <= 24'($urandom);
    $display("test levels done");
    @(posedge clk);
    {rlf, hb, ae} <= '0;
    sy <= '1;
    dk <= 1'b1;
    for (k = 0; k < 60 && o_al !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    check(o_al === 1'b1 && o_ps === 1'b1 && o_lf === 1'b0, "align");
    check(o_idx === idx, "lane index");
    check(o_ws === '1 && o_wd === '1, "lane sync done");
    if (o_al !== 1'b1) wrap_up();
    @(posedge clk) hb <= 1'b1;
    repeat (2) @(negedge clk);
    check(o_ps === 1'b0, "status in high ber");
    @(posedge clk) bad <= 20'($urandom) | 20'h00001;
    repeat (4) @(posedge clk);
    bad <= '0;
    for (k = 0; k < 80 && o_mp !== 1'b1; k++) @(negedge clk);
    check(o_mp === 1'b1, "no misalignment");
    if (o_mp !== 1'b1) wrap_up();
    @(negedge clk);
    check(o_mp === 1'b0, "long misalignment");
    $display("test misalign done");
    @(posedge clk) {bad, ivl} <= {20'hFFFFF, 16'h0100};
    for (k = 0; k < 80 && (&o_rep & &o_sp) !== 1'b1; k++) @(negedge clk);
    check((&o_rep & &o_sp) === 1'b1, "spacing or repeat");
    if ((&o_rep & &o_sp) !== 1'b1) wrap_up();
    @(posedge clk) hl <= 20'h80001;
    repeat (2) @(negedge clk);
    check(o_we[19] === 1'b1 && o_we[0] === 1'b1, "wordsync error");
    @(posedge clk) rst_n <= 1'b0;
    @(negedge clk);
    check({o_sp, o_rep, o_we, o_al, o_mp, o_ws, o_wd} === '0, "mid-run reset");
    $display("test errors done");
    wrap_up();
  end
endmodule
bind rx_pcs_lane_align_status rx_status_chk i_chk (.*);
